// ===== core/flash_cycle.sv
// one asynchronous flash bus cycle, read or write, from a held request
`timescale 1ns/1ns
module flash_cycle #(
   parameter int SETUP  = flash_host_pkg::SETUP_CYC,
   parameter int PULSE  = flash_host_pkg::PULSE_CYC,
   parameter int HOLD   = flash_host_pkg::HOLD_CYC
) (
   input  wire logic                       pclk,
   input  wire logic                       presetn,
   input  wire logic                       go,
   input  flash_host_pkg::cycle_req_t      req,
   output flash_host_pkg::flash_pins_t     pins,
   input  wire logic [7:0]                 flash_dq_i,
   output logic [7:0]                      rdata,
   output logic                            done
);
   import flash_host_pkg::*;

   if (SETUP < 1 || HOLD < 1 || PULSE <= GLITCH_CYC || PULSE + SYNC_CYC > 255) begin : g_chk
      $error("flash_cycle: timing counts out of range");
   end

   typedef enum {C_IDLE, C_SETUP, C_ACTIVE, C_HOLD} cyc_state_t;
   cyc_state_t state;
   logic [7:0] cnt;
   logic [7:0] dq_meta;
   logic [7:0] dq_sync;
   logic       wr_q;

   // read strobe is stretched so the synchronised data has settled
   wire logic [7:0] active_len = wr_q ? 8'(PULSE - 1) : 8'(PULSE + SYNC_CYC - 1);
   wire logic       cnt_zero   = (cnt == 8'h00);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dq_meta <= 8'h00;
         dq_sync <= 8'h00;
      end else begin
         dq_meta <= flash_dq_i;
         dq_sync <= dq_meta;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= C_IDLE;
         cnt   <= 8'h00;
         wr_q  <= 1'b0;
         done  <= 1'b0;
         rdata <= 8'h00;
         pins  <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, default: '0};
      end else begin
         done <= 1'b0;
         case (state)
            C_IDLE: begin
               if (go && !done) begin
                  pins.addr  <= req.addr;
                  pins.dq_o  <= req.data;
                  pins.dq_oe <= req.wr;
                  pins.ce_n  <= 1'b0;
                  wr_q       <= req.wr;
                  cnt        <= 8'(SETUP - 1);
                  state      <= C_SETUP;
               end
            end
            C_SETUP: begin
               if (cnt_zero) begin
                  pins.we_n <= !wr_q;
                  pins.oe_n <= wr_q;
                  cnt       <= active_len;
                  state     <= C_ACTIVE;
               end else begin
                  cnt <= cnt - 8'h01;
               end
            end
            C_ACTIVE: begin
               if (cnt_zero) begin
                  pins.we_n <= 1'b1;
                  pins.oe_n <= 1'b1;
                  if (!wr_q) begin
                     rdata <= dq_sync;
                  end
                  cnt   <= 8'(HOLD - 1);
                  state <= C_HOLD;
               end else begin
                  cnt <= cnt - 8'h01;
               end
            end
            C_HOLD: begin
               if (cnt_zero) begin
                  pins.ce_n  <= 1'b1;
                  pins.dq_oe <= 1'b0;
                  done       <= 1'b1;
                  state      <= C_IDLE;
               end else begin
                  cnt <= cnt - 8'h01;
               end
            end
            default: state <= C_IDLE;
         endcase
      end
   end

   sequence we_low_pulse;
      !pins.we_n[*5];
   endsequence

   write_inhibit_a: assert property (@(posedge pclk) disable iff (!presetn)
      !pins.we_n |-> (!pins.ce_n && pins.oe_n && pins.dq_oe))
      else $error("write strobe low without chip select or with output enable");
   we_width_a: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(pins.we_n) |-> we_low_pulse ##1 pins.we_n)
      else $error("write strobe pulse width wrong");
   read_cycle_a: assert property (@(posedge pclk) disable iff (!presetn)
      $fell(pins.oe_n) |-> pins.we_n && !pins.ce_n && !pins.dq_oe)
      else $error("read strobe while writing or deselected");
endmodule

// ===== core/flash_host.sv
// apb-driven flash command and status-polling controller
//
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/1ns
module flash_host (
   input  wire logic                   pclk,
   input  wire logic                   presetn,
   input  wire logic                   psel,
   input  wire logic                   penable,
   input  wire logic                   pwrite,
   input  wire logic [11:0]            paddr,
   input  wire logic [31:0]            pwdata,
   output logic [31:0]                 prdata,
   output logic                        pready,
   output logic                        pslverr,
   output flash_host_pkg::flash_pins_t flash_pins,
   input  wire logic [7:0]             flash_dq_i
);
   import flash_host_pkg::*;

   typedef enum {
      M_IDLE, M_WRITE, M_POLL_A, M_POLL_B, M_RCHK_A, M_RCHK_B,
      M_ADD_PRE, M_ADD_WR, M_ADD_POST, M_READ
   } main_state_t;

   main_state_t       state;
   op_t               op;
   logic [2:0]        step;
   logic              first_tog;
   logic              ok;
   logic              fail;
   logic              reject;
   logic [7:0]        last_byte;
   logic [7:0]        rd_byte;
   logic [ADDR_W-1:0] tgt_addr;
   logic [7:0]        tgt_data;
   logic [11:0]       win_cnt;
   logic [3:0]        wr_seen;
   cycle_req_t        creq;
   logic [7:0]        cyc_rdata;
   logic              cyc_done;

   // apb decode
   wire logic setup_ph  = psel && !penable;
   wire logic access_wr = psel && penable && pwrite && !pslverr;
   wire logic hit_ctrl  = (paddr == OFS_CTRL);
   wire logic hit_addr  = (paddr == OFS_ADDR);
   wire logic hit_data  = (paddr == OFS_DATA);
   wire logic hit_stat  = (paddr == OFS_STATUS);
   wire logic hit_rdat  = (paddr == OFS_RDATA);
   wire logic hit_any   = hit_ctrl | hit_addr | hit_data | hit_stat | hit_rdat;
   wire logic busy      = (state != M_IDLE);
   wire op_t  new_op    = op_t'(pwdata[2:0]);
   wire logic go_cmd    = access_wr && hit_ctrl && pwdata[CTRL_GO] && !busy
                          && (new_op != OP_NONE);

   // sector-load window measured from the last write strobe rise
   wire logic win_open  = (32'(win_cnt) + WIN_MARGIN) < WINDOW_CYC;

   wire logic [31:0] status_word =
        (32'(busy)     << ST_BUSY)   | (32'(ok)       << ST_OK)
      | (32'(fail)     << ST_FAIL)   | (32'(reject)   << ST_REJECT)
      | (32'(win_open) << ST_WINOPEN) | (32'(last_byte) << ST_BYTE);

   wire logic [31:0] read_mux =
        hit_ctrl ? {29'h0, op}     : hit_addr ? 32'(tgt_addr)
      : hit_data ? 32'(tgt_data)   : hit_stat ? status_word
      : hit_rdat ? 32'(rd_byte)    : 32'h0000_0000;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
         pready  <= 1'b0;
      end else begin
         pready <= 1'b1;
         if (setup_ph) begin
            prdata  <= pwrite ? 32'h0000_0000 : read_mux;
            pslverr <= !hit_any;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tgt_addr <= '0;
         tgt_data <= 8'h00;
      end else if (access_wr && !busy) begin
         if (hit_addr) tgt_addr <= pwdata[ADDR_W-1:0];
         if (hit_data) tgt_data <= pwdata[7:0];
      end
   end

   // command sequence table
   wire logic [2:0] seq_last = (op == OP_PROGRAM) ? LAST_PROGRAM
                             : (op == OP_ERASE)   ? LAST_ERASE : 3'h0;
   wire logic       seq_tgt  = (step == seq_last) && (op != OP_RESET);
   wire logic       seq_u2   = (step == 3'h1) || (step == 3'h4);
   wire logic [ADDR_W-1:0] seq_addr = seq_tgt ? tgt_addr
                                    : seq_u2  ? UNLOCK_ADDR2 : UNLOCK_ADDR1;
   logic [7:0] seq_data;
   always_comb begin
      seq_data = CMD_UNLOCK1;
      if (op == OP_RESET) begin
         seq_data = CMD_RESET;
      end else if (seq_u2) begin
         seq_data = CMD_UNLOCK2;
      end else if (op == OP_PROGRAM && step == 3'h2) begin
         seq_data = CMD_PROGRAM;
      end else if (op == OP_PROGRAM && seq_tgt) begin
         seq_data = tgt_data;
      end else if (op == OP_ERASE && step == 3'h2) begin
         seq_data = CMD_ERASE_SETUP;
      end else if (op == OP_ERASE && seq_tgt) begin
         seq_data = CMD_SECTOR_ERASE;
      end
   end

   wire logic is_wr   = (state == M_WRITE) || (state == M_ADD_WR);
   wire logic tog_now = cyc_rdata[TOGGLE_BIT_ONE];
   wire logic tog_eq  = (tog_now == first_tog);
   wire logic to_flag = cyc_rdata[TIMEOUT_FLAG];
   wire logic win_flg = cyc_rdata[ERASE_WINDOW_FLAG];

   assign creq.wr   = is_wr;
   assign creq.addr = (state == M_WRITE) ? seq_addr : tgt_addr;
   assign creq.data = (state == M_WRITE) ? seq_data : CMD_SECTOR_ERASE;

   flash_cycle u_cycle (
      .pclk       (pclk),
      .presetn    (presetn),
      .go         (busy),
      .req        (creq),
      .pins       (flash_pins),
      .flash_dq_i (flash_dq_i),
      .rdata      (cyc_rdata),
      .done       (cyc_done)
   );

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         win_cnt <= 12'(WINDOW_CYC);
      end else if (cyc_done && is_wr) begin
         win_cnt <= 12'h000;
      end else if (32'(win_cnt) < WINDOW_CYC) begin
         win_cnt <= win_cnt + 12'h001;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         last_byte <= 8'h00;
         rd_byte   <= 8'h00;
      end else if (cyc_done && !is_wr) begin
         last_byte <= cyc_rdata;
         if (state == M_READ) rd_byte <= cyc_rdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state     <= M_IDLE;
         op        <= OP_NONE;
         step      <= 3'h0;
         first_tog <= 1'b0;
         ok        <= 1'b0;
         fail      <= 1'b0;
         reject    <= 1'b0;
      end else if (go_cmd) begin
         op     <= new_op;
         step   <= 3'h0;
         ok     <= 1'b0;
         fail   <= 1'b0;
         reject <= 1'b0;
         case (new_op)
            OP_ADD_SECTOR: state <= M_ADD_PRE;
            OP_POLL:       state <= M_POLL_A;
            OP_READ:       state <= M_READ;
            default:       state <= M_WRITE;
         endcase
      end else if (cyc_done) begin
         case (state)
            M_WRITE: begin
               if (step != seq_last) begin
                  step <= step + 3'h1;
               end else if (op == OP_PROGRAM) begin
                  state <= M_POLL_A;
               end else begin
                  // erase returns at once so extra sectors can still be loaded
                  ok    <= !fail;
                  state <= M_IDLE;
               end
            end
            M_POLL_A: begin
               first_tog <= tog_now;
               state     <= M_POLL_B;
            end
            M_POLL_B: begin
               first_tog <= tog_now;
               if (tog_eq) begin
                  ok    <= 1'b1;
                  state <= M_IDLE;
               end else if (to_flag) begin
                  state <= M_RCHK_A;
               end else begin
                  state <= M_POLL_A;
               end
            end
            M_RCHK_A: begin
               first_tog <= tog_now;
               state     <= M_RCHK_B;
            end
            M_RCHK_B: begin
               if (tog_eq) begin
                  ok    <= 1'b1;
                  state <= M_IDLE;
               end else begin
                  fail  <= 1'b1;
                  op    <= OP_RESET;
                  step  <= 3'h0;
                  state <= M_WRITE;
               end
            end
            M_ADD_PRE: begin
               // erase already running or window nearly shut: do not write
               if (win_flg || !win_open) begin
                  reject <= 1'b1;
                  state  <= M_IDLE;
               end else begin
                  state <= M_ADD_WR;
               end
            end
            M_ADD_WR: state <= M_ADD_POST;
            M_ADD_POST: begin
               reject <= win_flg;
               ok     <= !win_flg;
               state  <= M_IDLE;
            end
            M_READ: begin
               ok    <= 1'b1;
               state <= M_IDLE;
            end
            default: state <= M_IDLE;
         endcase
      end
   end

   // helper: write strobes completed since the command started
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         wr_seen <= 4'h0;
      end else if (go_cmd) begin
         wr_seen <= 4'h0;
      end else if (cyc_done && is_wr) begin
         wr_seen <= wr_seen + 4'h1;
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence poll_pair_same;
      state == M_POLL_B && cyc_done && tog_eq;
   endsequence

   prog_strobes_a: assert property (
      $rose(state == M_POLL_A) && op == OP_PROGRAM |-> wr_seen == 4'h4)
      else $error("program polling began before the fourth strobe");
   erase_strobes_a: assert property (
      state == M_WRITE && op == OP_ERASE && cyc_done && step == LAST_ERASE
      |=> wr_seen == 4'h6 && state == M_IDLE && ok)
      else $error("erase sequence did not end after six strobes");
   poll_pair_a: assert property (
      poll_pair_same |=> state == M_IDLE && ok && !fail)
      else $error("two equal toggle reads did not finish the poll");
   timeout_check_a: assert property (
      state == M_POLL_B && cyc_done && !tog_eq && to_flag |=> state == M_RCHK_A)
      else $error("timeout flag did not trigger the recheck");
   timeout_reset_a: assert property (
      state == M_RCHK_B && cyc_done && !tog_eq
      |=> state == M_WRITE && op == OP_RESET && fail ##[1:200] state == M_IDLE)
      else $error("failed operation not followed by a reset command");
   window_check_a: assert property (
      state == M_ADD_PRE && cyc_done && win_flg |=> state == M_IDLE && reject)
      else $error("extra sector written although erase already started");
   window_time_a: assert property (
      $rose(state == M_ADD_WR) |-> 32'(win_cnt) < WINDOW_CYC)
      else $error("extra sector write outside the load window");
   apb_answer_a: assert property (
      setup_ph |=> pready && (pslverr == !$past(hit_any)))
      else $error("apb access answered wrongly");
endmodule

// ===== core/flash_host_pkg.sv
// constants, types and layouts shared by the flash status-polling controller
// Notes on behaviour
// - host reads twice in a row; unchanged toggle bit means finished
// - still toggling: check timeout flag, recheck, then issue reset command
// - after an erase timeout host issues reset before further operations
// - host reads erase window flag before and after each extra sector command
// - write needs chip select and write strobe low with output enable high
// - each extra sector write starts within 30 us of the last strobe rise
package flash_host_pkg;
   localparam int CLK_MHZ          = 100;
   localparam int SETUP_NS         = 10;
   localparam int PULSE_NS         = 50;
   localparam int HOLD_NS          = 20;
   localparam int GLITCH_NS        = 5;
   localparam int SECTOR_WINDOW_US = 30;
   localparam int SETUP_CYC  = (SETUP_NS * CLK_MHZ + 999) / 1000;
   localparam int PULSE_CYC  = (PULSE_NS * CLK_MHZ + 999) / 1000;
   localparam int HOLD_CYC   = (HOLD_NS * CLK_MHZ + 999) / 1000;
   localparam int GLITCH_CYC = (GLITCH_NS * CLK_MHZ + 999) / 1000;
   localparam int WINDOW_CYC = SECTOR_WINDOW_US * CLK_MHZ;
   localparam int SYNC_CYC   = 2;
   localparam int WIN_MARGIN = 2 * SETUP_CYC + PULSE_CYC + HOLD_CYC + SYNC_CYC + 4;
   localparam int ADDR_W     = 18;

   localparam logic [11:0] OFS_CTRL   = 12'h000;
   localparam logic [11:0] OFS_ADDR   = 12'h004;
   localparam logic [11:0] OFS_DATA   = 12'h008;
   localparam logic [11:0] OFS_STATUS = 12'h00C;
   localparam logic [11:0] OFS_RDATA  = 12'h010;

   localparam int CTRL_GO    = 8;
   localparam int ST_BUSY    = 0;
   localparam int ST_OK      = 1;
   localparam int ST_FAIL    = 2;
   localparam int ST_REJECT  = 3;
   localparam int ST_WINOPEN = 4;
   localparam int ST_BYTE    = 8;

   localparam int POLLING_BIT       = 7;
   localparam int TOGGLE_BIT_ONE    = 6;
   localparam int TIMEOUT_FLAG      = 5;
   localparam int ERASE_WINDOW_FLAG = 3;
   localparam int TOGGLE_BIT_TWO    = 2;

   localparam logic [7:0]        CMD_UNLOCK1      = 8'hAA;
   localparam logic [7:0]        CMD_UNLOCK2      = 8'h55;
   localparam logic [7:0]        CMD_PROGRAM      = 8'hA0;
   localparam logic [7:0]        CMD_ERASE_SETUP  = 8'h80;
   localparam logic [7:0]        CMD_SECTOR_ERASE = 8'h30;
   localparam logic [7:0]        CMD_RESET        = 8'hF0;
   localparam logic [ADDR_W-1:0] UNLOCK_ADDR1     = 18'h00555;
   localparam logic [ADDR_W-1:0] UNLOCK_ADDR2     = 18'h002AA;
   localparam logic [2:0]        LAST_PROGRAM     = 3'h3;
   localparam logic [2:0]        LAST_ERASE       = 3'h5;

   typedef enum logic [2:0] {
      OP_NONE, OP_PROGRAM, OP_ERASE, OP_ADD_SECTOR, OP_POLL, OP_RESET, OP_READ
   } op_t;

   typedef struct packed {
      logic              ce_n;
      logic              oe_n;
      logic              we_n;
      logic [ADDR_W-1:0] addr;
      logic [7:0]        dq_o;
      logic              dq_oe;
   } flash_pins_t;

   typedef struct packed {
      logic              wr;
      logic [ADDR_W-1:0] addr;
      logic [7:0]        data;
   } cycle_req_t;
endpackage

// ===== tb/flash_model.sv
// behavioural flash device answering the controller's bus cycles
`timescale 1ns/1ns
module flash_model #(
   parameter int PROG_RDS  = 3,
   parameter int ERASE_RDS = 4,
   parameter int TMO_RDS   = 6,
   parameter int WIN_NS    = 30000,
   parameter int PROT_RDS  = 2,
   parameter logic [3:0] PROT_SECT   = 4'hF,
   parameter logic [7:0] SUSPEND_CMD = 8'hB0,
   // resume code is arbitrary; the controller never suspends
   parameter logic [7:0] RESUME_CMD  = 8'h31
) (
   input  flash_host_pkg::flash_pins_t pins,
   input  wire logic                   stuck,
   output logic [7:0]                  dq
);
   import flash_host_pkg::*;
   logic [7:0]  mem [0:255];
   logic [7:0]  last, rd_val, pdata;
   logic [15:0] sel;
   logic        prog, erase, tog1, tog2, tmo, susp;
   int          step, left, nrd, writes, resets, sectors, bad;
   time         t_fall, t_win;

   function automatic logic win_closed();
      return erase && ($time - t_win >= WIN_NS);
   endfunction

   function automatic logic is_prot();
      return pins.addr[17:14] == PROT_SECT;
   endfunction

   initial begin
      for (int i = 0; i < 256; i++) mem[i] = 8'hFF;
      {prog, erase, tog1, tog2, tmo, susp} = '0;
      {step, writes, resets, sectors, bad, t_fall, t_win} = '0;
      {sel, last, rd_val, pdata} = '0;
   end

   always @(negedge pins.we_n) begin
      t_fall = $time;
      if (!pins.oe_n || pins.ce_n) bad++;
   end

   // short strobes and blocked cycles never reach the command decoder
   always @(posedge pins.we_n) if (!pins.ce_n && pins.oe_n && $time - t_fall >= 5) begin
      writes++;
      if (pins.dq_o == CMD_RESET && !win_closed()) begin
         resets++;
         {prog, erase, tmo, susp, step, sel} = '0;
      end else if (erase && !prog && pins.dq_o == SUSPEND_CMD) begin
         susp = 1'b1;
      end else if (susp && !prog && pins.dq_o == RESUME_CMD) begin
         susp = 1'b0;
         left = ERASE_RDS;
      end else if (prog || (win_closed() && !susp)) begin
         step = 0;
      end else if (erase && !susp && pins.dq_o == CMD_SECTOR_ERASE) begin
         sel[pins.addr[17:14]] = !is_prot();
         sectors++;
         t_win = $time;
      end else begin
         case (step)
            0: step = (pins.dq_o == CMD_UNLOCK1 && pins.addr == UNLOCK_ADDR1) ? 1 : 0;
            1: step = (pins.dq_o == CMD_UNLOCK2 && pins.addr == UNLOCK_ADDR2) ? 2 : 0;
            2: step = pins.dq_o == CMD_PROGRAM ? 3 : pins.dq_o == CMD_ERASE_SETUP ? 4 : 0;
            3: begin
               prog  = 1'b1;
               pdata = pins.dq_o;
               nrd   = 0;
               step  = 0;
               // protected target: brief toggling, array left untouched
               left  = is_prot() ? PROT_RDS : PROG_RDS;
               if (!is_prot()) mem[pins.addr[7:0]] = pins.dq_o;
            end
            4: step = pins.dq_o == CMD_UNLOCK1 ? 5 : 0;
            5: step = pins.dq_o == CMD_UNLOCK2 ? 6 : 0;
            default: begin
               if (pins.dq_o == CMD_SECTOR_ERASE) begin
                  erase   = 1'b1;
                  sel     = 16'h0000;
                  sectors = 1;
                  t_win   = $time;
                  sel[pins.addr[17:14]] = !is_prot();
                  left    = (sel == 16'h0000) ? PROT_RDS : ERASE_RDS;
               end
               step = 0;
            end
         endcase
      end
   end

   always @(negedge pins.oe_n) if (!pins.ce_n) begin
      if (pins.dq_oe) bad++;
      if (prog || (erase && (!susp || sel[pins.addr[17:14]])))
         rd_val = {prog ? ~pdata[7] : 1'b0, tog1, tmo, 1'b0, win_closed(),
                   tog2 && sel[pins.addr[17:14]], 2'b00};
      else
         rd_val = mem[pins.addr[7:0]];
   end

   // toggle two advances once per finished read, toggle one too unless erase is suspended, so a pair differs while busy
   always @(posedge pins.oe_n) if (!pins.ce_n) begin
      last = rd_val;
      tog2 = ~tog2;
      // suspended erase freezes toggle one unless a program runs
      if (!susp || prog) tog1 = ~tog1;
      nrd++;
      if (prog && stuck) begin
         if (nrd >= TMO_RDS) tmo = 1'b1;
      end else if (prog || (erase && !susp && (win_closed() || sel == 16'h0000))) begin
         left--;
         if (left == 0 && prog) prog = 1'b0;
         else if (left == 0) erase = 1'b0;
      end
   end

   // released bus shows the inverse of the last byte, not a held value
   assign dq = (!pins.ce_n && !pins.oe_n) ? rd_val : ~last;
endmodule

// ===== tb/tb.sv
// self-checking bench for the apb flash status-polling controller
`timescale 1ns/1ns
module tb;
   import flash_host_pkg::*;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, stuck, err;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [7:0]  dq;
   flash_pins_t pins;
   int          miscompares = 0;
   int          check_count = 0;
   int          cycles = 0;
   int          w0, r0;
   logic [7:0]  b0;

   flash_host dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .flash_pins(pins), .flash_dq_i(dq));
   flash_model model_u (.pins(pins), .stuck(stuck), .dq(dq));

   initial begin
      pclk = 0;
      forever #5 pclk = ~pclk;
   end

   always @(posedge pclk) begin
      cycles++;
      if (cycles == 60000) begin
         miscompares++;
         final_report();
      end
   end

   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wr, a, wd};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
   endtask

   task automatic run_op(input logic [2:0] op, input logic [17:0] a, input logic [7:0] d);
      w0 = model_u.writes;
      r0 = model_u.resets;
      apb(1'b1, OFS_ADDR, 32'(a));
      apb(1'b1, OFS_DATA, 32'(d));
      apb(1'b1, OFS_CTRL, 32'(op) | (32'h1 << CTRL_GO));
      do apb(1'b0, OFS_STATUS, 32'h0); while (rd[ST_BUSY] !== 1'b0);
   endtask

   task automatic t_bus();
      apb(1'b0, 12'hFF0, 32'h0);
      check("unmapped_err", err, 1'b1);
      check("unmapped_data", rd, 32'h0);
      run_op(3'h6, 18'h00012, 8'h00);
      apb(1'b0, OFS_RDATA, 32'h0);
      check("read_op", rd[7:0], model_u.mem[8'h12]);
      run_op(3'h5, 18'h0, 8'h00);
      check("reset_op", model_u.resets - r0, 1);
      $display("test bus done");
   endtask

   task automatic t_program();
      run_op(3'h1, 18'h00012, 8'hA5);
      check("prog_ok", rd[2:1], 2'b01);
      check("prog_byte", rd[15:8], 8'hA5);
      check("prog_writes", model_u.writes - w0, 4);
      check("prog_mem", model_u.mem[8'h12], 8'hA5);
      stuck <= 1'b1;
      run_op(3'h1, 18'h00034, 8'h3C);
      check("stuck_fail", rd[2:1], 2'b10);
      check("stuck_reset", model_u.resets - r0, 1);
      stuck <= 1'b0;
      run_op(3'h1, 18'h00056, 8'h5A);
      check("after_fail_ok", rd[2:1], 2'b01);
      run_op(3'h1, 18'h3C012, 8'h00);
      check("prot_prog_ok", rd[2:1], 2'b01);
      check("prot_prog_mem", model_u.mem[8'h12], 8'hA5);
      $display("test program done");
   endtask

   task automatic t_erase();
      run_op(3'h2, 18'h10000, 8'h00);
      check("erase_ok", rd[ST_OK], 1'b1);
      check("erase_writes", model_u.writes - w0, 6);
      run_op(3'h3, 18'h14000, 8'h00);
      check("add_reject", rd[ST_REJECT], 1'b0);
      check("add_sectors", model_u.sectors, 2);
      repeat (3100) @(posedge pclk);
      run_op(3'h3, 18'h18000, 8'h00);
      check("late_reject", rd[ST_REJECT], 1'b1);
      check("late_writes", model_u.writes - w0, 0);
      run_op(3'h6, 18'h10000, 8'h00);
      apb(1'b0, OFS_RDATA, 32'h0);
      b0 = rd[7:0];
      run_op(3'h6, 18'h10000, 8'h00);
      apb(1'b0, OFS_RDATA, 32'h0);
      check("erase_polling", rd[7], 1'b0);
      check("erase_started", rd[3], 1'b1);
      check("toggle_one", rd[6] ^ b0[6], 1'b1);
      check("toggle_two", rd[2] ^ b0[2], 1'b1);
      run_op(3'h4, 18'h10000, 8'h00);
      check("poll_ok", rd[2:1], 2'b01);
      check("poll_done", model_u.erase, 1'b0);
      check("poll_byte", rd[15:8], 8'hFF);
      run_op(3'h2, 18'h3C000, 8'h00);
      run_op(3'h4, 18'h3C000, 8'h00);
      check("prot_erase_ok", rd[2:1], 2'b01);
      check("prot_erase_done", model_u.erase, 1'b0);
      check("strobe_rules", model_u.bad, 0);
      $display("test erase done");
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, stuck} = '0;
      repeat (9) @(posedge pclk);
      check("pready_rst", pready, 1'b0);
      check("pins_rst", {pins.ce_n, pins.oe_n, pins.we_n, pins.dq_oe}, 4'hE);
      @(posedge pclk);
      presetn <= 1'b1;
      repeat (2) @(posedge pclk);
      check("pready_run", pready, 1'b1);
      t_bus();
      t_program();
      t_erase();
      final_report();
   end
endmodule
